//--- hw/rscd_cfg.svh
// register offsets, field positions, reset values and switch timing for the clock select block
// assumes inclusion from the package, the top module and the bench only
`ifndef RSCD_CFG_SVH
`define RSCD_CFG_SVH
`define RSCD_OFF_AUX3_STAT 12'h02c
`define RSCD_OFF_REF_CTRL 12'h030
`define RSCD_OFF_REF_DIV 12'h034
`define RSCD_OFF_REF_STAT 12'h038
`define RSCD_OFF_SYS_CTRL 12'h03c
`define RSCD_OFF_SYS_DIV 12'h040
`define RSCD_OFF_SYS_STAT 12'h044
`define RSCD_REF_AUX_HI 6
`define RSCD_REF_AUX_LO 5
`define RSCD_REF_SRC_HI 1
`define RSCD_REF_SRC_LO 0
`define RSCD_REF_INT_HI 9
`define RSCD_REF_INT_LO 8
`define RSCD_SYS_AUX_HI 7
`define RSCD_SYS_AUX_LO 5
`define RSCD_SYS_SRC_BIT 0
`define RSCD_SYS_INT_HI 31
`define RSCD_SYS_INT_LO 8
`define RSCD_SYS_DIVISOR_FRACTION_HI 7
`define RSCD_SYS_DIVISOR_FRACTION_LO 0
`define RSCD_AUX3_STAT_RST 32'h0000_0001
`define RSCD_REF_INT_RST 2'h1
`define RSCD_SYS_INT_RST 24'h00_0001
`define RSCD_SYS_DIVISOR_FRACTION_RST 8'h00
`define RSCD_REF_SRC_RST 2'h0
`define RSCD_SYS_SRC_RST 1'h0
`define RSCD_AUX_RST 3'h0
// time in ns with no source passed while a glitchless change settles, rounded up to pclk cycles
`define RSCD_GAP_NS 20
`define RSCD_CLK_NS 5
`define RSCD_GAP_CYC ((`RSCD_GAP_NS + `RSCD_CLK_NS - 1) / `RSCD_CLK_NS)
`endif

//--- hw/rscd_pkg.sv
// types for the reference and system clock select and divide block
// assumes the constants header beside it
`include "rscd_cfg.svh"
package rscd_pkg;
  typedef enum logic [1:0] {
    RSCD_IDLE,
    RSCD_DROP,
    RSCD_GAP,
    RSCD_TAKE
  } rscd_sw_e;

  typedef struct packed {
    rscd_sw_e st;
    logic [2:0] cnt;
    logic [2:0] cur;
    logic [2:0] tgt;
  } rscd_glm_s;

  typedef struct packed {
    logic [1:0] ref_aux;
    logic [1:0] ref_src;
    logic [1:0] ref_int;
    logic [2:0] sys_aux;
    logic sys_src;
    logic [23:0] sys_int;
    logic [7:0] sys_divisor_fraction;
    rscd_glm_s ref_glm;
    rscd_glm_s sys_glm;
    logic [31:0] prdata;
  } rscd_state_s;

  typedef struct packed {
    logic [1:0] ref_aux;
    logic [1:0] ref_src;
    logic [1:0] ref_int;
    logic [2:0] sys_aux;
    logic sys_src;
    logic [23:0] sys_int;
    logic [7:0] sys_divisor_fraction;
  } rscd_cfg_s;
endpackage

//--- hw/rscd_top.sv
// apb register slave for the reference and system clock generators
// assumes a single pclk domain; clock muxes themselves sit outside and follow cfg and status
`timescale 1ns/1ps
`include "rscd_cfg.svh"

// What this block does
// - aux output three status always reads 0x00000001.
// - reference aux source at bits 6:5: usb pll, input 0, input 1.
// - reference glitchless source at bits 1:0: ring osc, ref aux, crystal.
// - reference divider integer at bits 9:8 resets to 1; zero means 65536.
// - dividers and non-aux control fields rewritable any time while running.
// - system aux source at bits 7:5, six sources from system pll on.
// - system glitchless source bit 0 resets 0: reference or system aux.
// - system divider: 24-bit integer at 31:8 reset 1, fraction 7:0 reset 0.
// - glitchless mux changes source over several cycles, never in one step.
// - status is one-hot by source code, read-only, resets to bit 0.
// - at most one status bit set; it marks the passed source.
// - during a switch the status may read all zeros.
module rscd_top
  import rscd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rscd_cfg_s cfg,
  output logic [31:0] ref_status,
  output logic [31:0] sys_status
);

  rscd_state_s s_q, s_d;

  // one-hot decode of a source code; used for both status words
  function automatic logic [31:0] onehot(input logic [2:0] c);
    logic [31:0] v;
    v = 32'h0;
    v[c] = 1'b1;
    return v;
  endfunction

  function automatic logic known_off(input logic [11:0] a);
    return (a == `RSCD_OFF_AUX3_STAT) || (a == `RSCD_OFF_REF_CTRL) ||
      (a == `RSCD_OFF_REF_DIV) || (a == `RSCD_OFF_REF_STAT) ||
      (a == `RSCD_OFF_SYS_CTRL) || (a == `RSCD_OFF_SYS_DIV) ||
      (a == `RSCD_OFF_SYS_STAT);
  endfunction

  // switch sequencer: drop old source, hold a gap, then take new one
  function automatic rscd_glm_s glm_step(input rscd_glm_s g, input logic [2:0] want);
    rscd_glm_s n;
    n = g;
    case (g.st)
      RSCD_IDLE: begin
        if (want != g.cur) begin
          n.tgt = want;
          n.st = RSCD_DROP;
        end
      end
      RSCD_DROP: begin
        n.st = RSCD_GAP;
        n.cnt = 3'(`RSCD_GAP_CYC);
      end
      RSCD_GAP: begin
        // a new request during the gap just retargets; no source is passed meanwhile
        n.tgt = want;
        if (g.cnt <= 3'h1) begin
          n.st = RSCD_TAKE;
        end else begin
          n.cnt = g.cnt - 3'h1;
        end
      end
      RSCD_TAKE: begin
        n.cur = g.tgt;
        n.st = RSCD_IDLE;
      end
      default: begin
        n.st = RSCD_IDLE;
      end
    endcase
    return n;
  endfunction

  function automatic logic [31:0] glm_status(input rscd_glm_s g);
    // old source is cut before status goes dark, new one shown once passed
    if (g.st == RSCD_GAP || g.st == RSCD_TAKE) begin
      return 32'h0;
    end
    return onehot(g.cur);
  endfunction

  logic acc, wr_acc, rd_acc;
  logic [31:0] wmask;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite && known_off(paddr);
  assign rd_acc = acc && !pwrite;
  generate
    for (genvar i = 0; i < 4; i++) begin : g_lane
      assign wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  endgenerate

  always_comb begin
    logic [31:0] w;
    logic [31:0] rd;
    w = 32'h0;
    rd = 32'h0;
    s_d = s_q;
    // fields written whenever the access lands, only where their byte lane strobe is set; no stall needed
    if (wr_acc) begin
      case (paddr)
        `RSCD_OFF_REF_CTRL: begin
          // old fields placed at their own bit positions so a masked lane keeps them
          w = (pwdata & wmask) | ({25'h0, s_q.ref_aux, 3'h0, s_q.ref_src} & ~wmask);
          s_d.ref_aux = w[`RSCD_REF_AUX_HI:`RSCD_REF_AUX_LO];
          s_d.ref_src = w[`RSCD_REF_SRC_HI:`RSCD_REF_SRC_LO];
        end
        `RSCD_OFF_REF_DIV: begin
          if (pstrb[1]) begin
            s_d.ref_int = pwdata[`RSCD_REF_INT_HI:`RSCD_REF_INT_LO];
          end
        end
        `RSCD_OFF_SYS_CTRL: begin
          if (pstrb[0]) begin
            s_d.sys_aux = pwdata[`RSCD_SYS_AUX_HI:`RSCD_SYS_AUX_LO];
            s_d.sys_src = pwdata[`RSCD_SYS_SRC_BIT];
          end
        end
        `RSCD_OFF_SYS_DIV: begin
          w = (pwdata & wmask) | ({s_q.sys_int, s_q.sys_divisor_fraction} & ~wmask);
          s_d.sys_int = w[`RSCD_SYS_INT_HI:`RSCD_SYS_INT_LO];
          s_d.sys_divisor_fraction = w[`RSCD_SYS_DIVISOR_FRACTION_HI:`RSCD_SYS_DIVISOR_FRACTION_LO];
        end
        default: begin
        end
      endcase
    end
    // reserved encodings are stored as written; the external mux treats them as off
    s_d.ref_glm = glm_step(s_q.ref_glm, {1'b0, s_q.ref_src});
    s_d.sys_glm = glm_step(s_q.sys_glm, {2'b00, s_q.sys_src});
    if (rd_acc) begin
      case (paddr)
        `RSCD_OFF_AUX3_STAT: rd = `RSCD_AUX3_STAT_RST;
        `RSCD_OFF_REF_CTRL: rd = {25'h0, s_q.ref_aux, 3'h0, s_q.ref_src};
        `RSCD_OFF_REF_DIV: rd = {22'h0, s_q.ref_int, 8'h0};
        `RSCD_OFF_REF_STAT: rd = glm_status(s_q.ref_glm);
        `RSCD_OFF_SYS_CTRL: rd = {24'h0, s_q.sys_aux, 4'h0, s_q.sys_src};
        `RSCD_OFF_SYS_DIV: rd = {s_q.sys_int, s_q.sys_divisor_fraction};
        `RSCD_OFF_SYS_STAT: rd = glm_status(s_q.sys_glm);
        default: rd = 32'h0;
      endcase
      s_d.prdata = rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.ref_aux <= 2'(`RSCD_AUX_RST);
      s_q.ref_src <= `RSCD_REF_SRC_RST;
      s_q.ref_int <= `RSCD_REF_INT_RST;
      s_q.sys_aux <= `RSCD_AUX_RST;
      s_q.sys_src <= `RSCD_SYS_SRC_RST;
      s_q.sys_int <= `RSCD_SYS_INT_RST;
      s_q.sys_divisor_fraction <= `RSCD_SYS_DIVISOR_FRACTION_RST;
      s_q.ref_glm <= '{st: RSCD_IDLE, cnt: 3'h0, cur: 3'h0, tgt: 3'h0};
      s_q.sys_glm <= '{st: RSCD_IDLE, cnt: 3'h0, cur: 3'h0, tgt: 3'h0};
      s_q.prdata <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // registered read data: every access phase takes two cycles
  logic rd_wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= acc && !rd_wait_q;
    end
  end
  assign pready = rd_wait_q;
  assign pslverr = 1'b0;
  assign prdata = s_q.prdata;

  // software polls these; the divider zero case (65536) is applied by the divider itself
  assign cfg = '{ref_aux: s_q.ref_aux, ref_src: s_q.ref_src, ref_int: s_q.ref_int,
    sys_aux: s_q.sys_aux, sys_src: s_q.sys_src, sys_int: s_q.sys_int,
    sys_divisor_fraction: s_q.sys_divisor_fraction};
  assign ref_status = glm_status(s_q.ref_glm);
  assign sys_status = glm_status(s_q.sys_glm);

  a_ref_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(ref_status)) else $error("ref status not one-hot");
  a_sys_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(sys_status)) else $error("sys status not one-hot");
  a_ref_no_jump: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(ref_status) && $past(ref_status) != 32'h0) |-> ref_status == 32'h0)
    else $error("ref mux switched in one step");
  a_sys_no_jump: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(sys_status) && $past(sys_status) != 32'h0) |-> sys_status == 32'h0)
    else $error("sys mux switched in one step");
  a_ref_settles: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(cfg.ref_src) |-> ##[1:20] ref_status == onehot({1'b0, cfg.ref_src}))
    else $error("ref switch did not complete");
  a_sys_settles: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(cfg.sys_src) |-> ##[1:20] sys_status == onehot({2'b00, cfg.sys_src}))
    else $error("sys switch did not complete");
  a_aux3_const: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_AUX3_STAT) |=> prdata == 32'h1)
    else $error("aux3 status not constant one");
  a_refdiv_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `RSCD_OFF_REF_DIV && pstrb[1]) |=> cfg.ref_int == $past(pwdata[9:8]))
    else $error("ref divider not written");
  a_sysdiv_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `RSCD_OFF_SYS_DIV && pstrb == 4'hf) |=>
    {cfg.sys_int, cfg.sys_divisor_fraction} == $past(pwdata))
    else $error("sys divider not written");
  a_sysctl_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `RSCD_OFF_SYS_CTRL && pstrb[0]) |=>
    cfg.sys_aux == $past(pwdata[7:5]) && cfg.sys_src == $past(pwdata[0]))
    else $error("sys control not written");
  a_refctl_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `RSCD_OFF_REF_CTRL && pstrb == 4'hf) |=>
    cfg.ref_aux == $past(pwdata[6:5]) && cfg.ref_src == $past(pwdata[1:0]))
    else $error("ref control not written");
  a_refctl_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `RSCD_OFF_REF_CTRL && !pstrb[0]) |=> $stable(cfg.ref_aux))
    else $error("ref aux lost on masked write");
  a_refint_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `RSCD_OFF_REF_DIV && !pstrb[1]) |=> $stable(cfg.ref_int))
    else $error("ref divider changed without lane");
  a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_acc |=> $stable(cfg))
    else $error("config changed without write");
  a_ro_ref_stat: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && paddr == `RSCD_OFF_REF_STAT) |=> $stable(cfg))
    else $error("ref status write changed config");
  a_ro_sys_stat: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && paddr == `RSCD_OFF_SYS_STAT) |=> $stable(cfg))
    else $error("sys status write changed config");
  a_ref_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_REF_STAT) |=> prdata == $past(ref_status))
    else $error("ref status read wrong");
  a_sys_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_SYS_STAT) |=> prdata == $past(sys_status))
    else $error("sys status read wrong");
  a_refctl_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_REF_CTRL) |=>
    prdata == {25'h0, $past(cfg.ref_aux), 3'h0, $past(cfg.ref_src)})
    else $error("ref control read wrong");
  a_refdiv_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_REF_DIV) |=> prdata == {22'h0, $past(cfg.ref_int), 8'h0})
    else $error("ref divider read wrong");
  a_sysctl_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_SYS_CTRL) |=>
    prdata == {24'h0, $past(cfg.sys_aux), 4'h0, $past(cfg.sys_src)})
    else $error("sys control read wrong");
  a_sysdiv_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `RSCD_OFF_SYS_DIV) |=> prdata == {$past(cfg.sys_int), $past(cfg.sys_divisor_fraction)})
    else $error("sys divider read wrong");
  a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && !known_off(paddr)) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_acc |=> $stable(prdata))
    else $error("read data moved without read");
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held over two cycles");
  a_pready_access: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable)
    else $error("ready outside access phase");
  a_pready_next: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("ready late in access phase");
  a_slverr_low: assert property (@(posedge pclk) disable iff (!presetn)
    !pslverr)
    else $error("error response raised");
  a_ref_stat_range: assert property (@(posedge pclk) disable iff (!presetn)
    ref_status[31:4] == 28'h0)
    else $error("ref status bit beyond source codes");
  a_sys_stat_range: assert property (@(posedge pclk) disable iff (!presetn)
    sys_status[31:2] == 30'h0)
    else $error("sys status bit beyond source codes");
  // the gap is bounded: a dark status must come back within a few cycles
  a_ref_dark_short: assert property (@(posedge pclk) disable iff (!presetn)
    ref_status == 32'h0 |-> ##[1:8] ref_status != 32'h0)
    else $error("ref status dark too long");
  a_sys_dark_short: assert property (@(posedge pclk) disable iff (!presetn)
    sys_status == 32'h0 |-> ##[1:8] sys_status != 32'h0)
    else $error("sys status dark too long");
  a_ref_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ($stable(cfg.ref_src) && ref_status == onehot({1'b0, cfg.ref_src})) |=>
    ref_status == $past(ref_status))
    else $error("ref status moved while settled");
  a_sys_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ($stable(cfg.sys_src) && sys_status == onehot({2'b00, cfg.sys_src})) |=>
    sys_status == $past(sys_status))
    else $error("sys status moved while settled");
endmodule

//--- dv/rscd_tb.sv
// self-checking bench for the clock select and divide register block
// assumes rscd_top with an apb access ended by pready and in-design assertions
`timescale 1ns/1ps
`include "rscd_cfg.svh"
module testbench;
  import rscd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, zero_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ref_status, sys_status, rd, v;
  logic [3:0] pstrb;
  rscd_cfg_s cfg;
  int mismatches, total_checks, cycles;

  rscd_top u_rscd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg(cfg), .ref_status(ref_status),
    .sys_status(sys_status));

  always #2.5 pclk = ~pclk;

  // ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  always @(posedge pclk) begin
    if (presetn && (ref_status === 32'h0 || sys_status === 32'h0)) zero_seen <= 1'b1;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk_word(rd, exp);
    chk_flag(pslverr, 1'b0);
  endtask

  function automatic logic [31:0] ref_ctrl_w(input logic [1:0] aux, input logic [1:0] src);
    return {25'h0, aux, 3'h0, src};
  endfunction

  function automatic logic [31:0] sys_ctrl_w(input logic [2:0] aux, input logic src);
    return {24'h0, aux, 4'h0, src};
  endfunction

  // the switch is polled over the bus, as software would
  task automatic sw(input logic [11:0] ctl, input logic [11:0] stat, input logic [31:0] w,
                    input logic [2:0] code);
    int n;
    zero_seen = 1'b0;
    wr(ctl, w);
    apb(1'b0, stat, 32'h0, 4'hf);
    chk_flag(rd === (32'h1 << code), 1'b0);
    v = $urandom;
    wr(`RSCD_OFF_SYS_DIV, v);
    n = 0;
    while (rd !== (32'h1 << code) && n < 40) begin
      apb(1'b0, stat, 32'h0, 4'hf);
      chk_flag($countones(rd) <= 1, 1'b1);
      n++;
    end
    chk_word(rd, 32'h1 << code);
    chk_flag(zero_seen, 1'b1);
    rdchk(`RSCD_OFF_SYS_DIV, v);
  endtask

  task automatic reset_checks();
    rdchk(`RSCD_OFF_AUX3_STAT, 32'h0000_0001);
    rdchk(`RSCD_OFF_REF_CTRL, 32'h0000_0000);
    rdchk(`RSCD_OFF_REF_DIV, 32'h0000_0100);
    rdchk(`RSCD_OFF_REF_STAT, 32'h0000_0001);
    rdchk(`RSCD_OFF_SYS_CTRL, 32'h0000_0000);
    rdchk(`RSCD_OFF_SYS_DIV, 32'h0000_0100);
    rdchk(`RSCD_OFF_SYS_STAT, 32'h0000_0001);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    zero_seen = 1'b0;
    v = $urandom(32'h477bd5d2);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_checks();
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      wr(`RSCD_OFF_REF_CTRL, ref_ctrl_w(i % 3, 2'h0));
      rdchk(`RSCD_OFF_REF_CTRL, ref_ctrl_w(i % 3, 2'h0));
      chk_word({30'h0, cfg.ref_aux}, i % 3);
      wr(`RSCD_OFF_SYS_CTRL, sys_ctrl_w(i, 1'b0) | 32'hffff_ff00);
      rdchk(`RSCD_OFF_SYS_CTRL, sys_ctrl_w(i, 1'b0));
      v = (i == 0) ? 32'h0 : $urandom;
      wr(`RSCD_OFF_REF_DIV, v);
      rdchk(`RSCD_OFF_REF_DIV, v & 32'h0000_0300);
      v = $urandom;
      wr(`RSCD_OFF_SYS_DIV, v);
      rdchk(`RSCD_OFF_SYS_DIV, v);
      chk_word({cfg.sys_int, cfg.sys_divisor_fraction}, v);
    end
    $display("test fields_and_dividers done");
    wr(`RSCD_OFF_SYS_DIV, 32'hffff_ffff);
    apb(1'b1, `RSCD_OFF_SYS_DIV, 32'h0, 4'h1);
    rdchk(`RSCD_OFF_SYS_DIV, 32'hffff_ff00);
    // masked control write must keep the aux field at 6:5
    wr(`RSCD_OFF_REF_CTRL, ref_ctrl_w(2'h2, 2'h0));
    apb(1'b1, `RSCD_OFF_REF_CTRL, 32'h0, 4'h2);
    rdchk(`RSCD_OFF_REF_CTRL, ref_ctrl_w(2'h2, 2'h0));
    wr(`RSCD_OFF_AUX3_STAT, 32'hdead_beef);
    rdchk(`RSCD_OFF_AUX3_STAT, 32'h0000_0001);
    wr(`RSCD_OFF_REF_STAT, 32'h0000_0004);
    rdchk(`RSCD_OFF_REF_STAT, 32'h0000_0001);
    wr(12'h048, 32'h1234_5678);
    rdchk(12'h048, 32'h0);
    rdchk(12'h000, 32'h0);
    $display("test strobes_and_read_only done");
    sw(`RSCD_OFF_REF_CTRL, `RSCD_OFF_REF_STAT, ref_ctrl_w(2'h1, 2'h2), 3'h2);
    sw(`RSCD_OFF_REF_CTRL, `RSCD_OFF_REF_STAT, ref_ctrl_w(2'h1, 2'h1), 3'h1);
    sw(`RSCD_OFF_REF_CTRL, `RSCD_OFF_REF_STAT, ref_ctrl_w(2'h1, 2'h0), 3'h0);
    sw(`RSCD_OFF_SYS_CTRL, `RSCD_OFF_SYS_STAT, sys_ctrl_w(3'h3, 1'b1), 3'h1);
    sw(`RSCD_OFF_SYS_CTRL, `RSCD_OFF_SYS_STAT, sys_ctrl_w(3'h3, 1'b0), 3'h0);
    sw(`RSCD_OFF_REF_CTRL, `RSCD_OFF_REF_STAT, ref_ctrl_w(2'h2, 2'h2), 3'h2);
    $display("test glitchless_switch done");
    // second reset in mid-run, with the reference mux away from its reset source
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_checks();
    $display("test mid_run_reset done");
    final_report();
  end
endmodule
